// ===== swc_sleep_ctrl.sv
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

//Contract
//- sleep clears watchdog and power-down, sets time-out, stops oscillator
//- port pins keep their pre-sleep drive and enable during sleep
//- wake only on master clear, watchdog, or enabled interrupt source
//- master clear resets the device; other wake sources just resume
//- power-down set at power-up; time-out cleared on any watchdog expiry
//- only clock-independent peripherals may wake the device
//- core-clocked peripherals cannot flag interrupts while asleep
//- sleep prefetches the instruction at the next address
//- wake needs the source enable; global enable is ignored for wake
//- after irq wake run next instruction, then vector if global enable
//- pending enabled flag turns sleep into a no-op
//- irq during or after sleep: sleep completes fully, then wakes at once
//- watchdog expiry resets when awake, wakes when asleep
//- asleep, the watchdog cannot reset but can still wake
module swc_sleep_ctrl
  import swc_pkg::*;
#(
  parameter int WDT_TICK_CYCLES = WDT_CYCLES
) (
  // clock and reset
  input  wire logic            clk_sys,
  input  wire logic            nrst,
  // register port
  input  wire swc_bus_req_s    bus_req,
  output logic [DW-1:0]        bus_rdata,
  // core handshake
  input  wire swc_core_req_s   core_req,
  output swc_core_ack_s        core_ack,
  output logic [12:0]          vector_addr,
  // wake sources, one-cycle pulses
  input  wire logic [NSRC-1:0] src_event,
  input  wire logic            master_clear_n,
  // ports as driven by the core
  input  wire logic [7:0]      port_drv,
  input  wire logic [7:0]      port_drv_oe,
  output logic [7:0]           port_out,
  output logic [7:0]           port_oe,
  // system
  output logic                 osc_run,
  output logic                 device_reset,
  output logic                 irq
);

  swc_regs_s r_reg;
  swc_regs_s r_next;
  logic      wdt_timeout;
  logic      wdt_enable;

  function automatic logic asleep(input swc_state_e s);
    return (s == ST_SLEEP) || (s == ST_OST);
  endfunction

  function automatic logic hit(input swc_bus_req_s q,
                               input logic [AW-1:0] ofs, input logic wr);
    return (wr ? q.wr : q.rd) && (q.addr == ofs);
  endfunction

  assign wdt_enable = r_reg.config_word[POS_WDT_FUSE];

  swc_watchdog #(
    .TICK_CYCLES (WDT_TICK_CYCLES)
  ) u_wdt (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .enable   (wdt_enable),
    .clear    (r_reg.wdt_clr),
    .post_on  (r_reg.option[POS_POST_ON]),
    .post_sel (r_reg.option[POS_PS_LO +: PS_W]),
    .timeout  (wdt_timeout)
  );

  always_comb begin
    logic [NSRC-1:0]  pending;
    logic [NSRC-1:0]  src_ok;
    logic [NSRC-1:0]  src_clr;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] ev_clr;
    logic             ext_clear;
    r_next           = r_reg;
    pending          = r_reg.src_flag & r_reg.src_en;
    src_ok           = '1;
    src_clr          = '0;
    ev               = '0;
    ev_clr           = '0;
    ext_clear        = !master_clear_n;
    r_next.wdt_clr   = core_req.wdt_clear_instr;
    r_next.dev_rst   = 1'b0;
    r_next.prefetch  = 1'b0;
    r_next.exec_next = 1'b0;
    r_next.vec_req   = 1'b0;
    r_next.sleep_nop = 1'b0;
    r_next.rdata     = '0;

    // clocks for core-clocked peripherals are gone while asleep
    if (asleep(r_reg.st)) begin
      src_ok = ~SRC_CORE_MASK;
    end

    // register writes
    if (hit(bus_req, OFS_OPTION, 1'b1)) begin
      r_next.option = bus_req.wdata[7:0];
    end
    if (hit(bus_req, OFS_CONFIG, 1'b1)) begin
      r_next.config_word = bus_req.wdata[7:0];
    end
    if (hit(bus_req, OFS_SRC_EN, 1'b1)) begin
      r_next.src_en = bus_req.wdata[NSRC-1:0];
    end
    if (hit(bus_req, OFS_SRC_FLAG, 1'b1)) begin
      src_clr = bus_req.wdata[NSRC-1:0];
    end
    if (hit(bus_req, OFS_CTRL, 1'b1)) begin
      r_next.global_irq_enable = bus_req.wdata[POS_IRQ_EN];
    end
    if (hit(bus_req, OFS_IRQ_STAT, 1'b1)) begin
      ev_clr = bus_req.wdata[IRQ_W-1:0];
    end
    if (hit(bus_req, OFS_IRQ_MASK, 1'b1)) begin
      r_next.irq_mask = bus_req.wdata[IRQ_W-1:0];
    end

    // watchdog expiry always clears time-out
    if (wdt_timeout) begin
      r_next.time_out_flag = 1'b0;
    end

    unique case (r_reg.st)
      ST_RUN: begin
        if (wdt_timeout) begin
          r_next.dev_rst = 1'b1;
          ev[IRQ_WDT_RST] = 1'b1;
        end else if (core_req.sleep_instr) begin
          if (|pending) begin
            // flags untouched, watchdog keeps its count
            r_next.sleep_nop = 1'b1;
            ev[IRQ_SLP_NOP]  = 1'b1;
          end else begin
            r_next.wdt_clr         = 1'b1;
            r_next.power_down_flag = 1'b0;
            r_next.time_out_flag   = 1'b1;
            r_next.prefetch        = 1'b1;
            r_next.st              = ST_SLEEP;
            ev[IRQ_SLEPT]          = 1'b1;
          end
        end
      end
      ST_SLEEP: begin
        // sleep already completed; a flag raised meanwhile wakes at once
        if (wdt_timeout || (|pending)) begin
          r_next.irq_wake = !wdt_timeout;
          r_next.cnt      = '0;
          r_next.st       = ST_OST;
        end
      end
      ST_OST: begin
        if (r_reg.cnt == OST_W'(OST_CYCLES - 1)) begin
          r_next.cnt = '0;
          r_next.st  = ST_EXEC;
        end else begin
          r_next.cnt = r_reg.cnt + OST_W'(1);
        end
      end
      ST_EXEC: begin
        // the prefetched instruction runs first, global enable or not
        r_next.exec_next = 1'b1;
        ev[IRQ_WOKE]     = 1'b1;
        if (r_reg.irq_wake && r_reg.global_irq_enable) begin
          r_next.st = ST_DUMMY;
        end else begin
          r_next.st = ST_RUN;
        end
      end
      ST_DUMMY: begin
        if (r_reg.cnt == OST_W'(DUMMY_CYCLES - 1)) begin
          r_next.cnt = '0;
          r_next.st  = ST_VEC;
        end else begin
          r_next.cnt = r_reg.cnt + OST_W'(1);
        end
      end
      ST_VEC: begin
        r_next.vec_req = 1'b1;
        r_next.st      = ST_RUN;
      end
      default: begin
        r_next.st = ST_RUN;
      end
    endcase

    // master clear wins over everything, asleep or awake
    if (ext_clear) begin
      r_next.dev_rst  = 1'b1;
      r_next.st       = ST_RUN;
      r_next.irq_wake = 1'b0;
      r_next.cnt      = '0;
    end

    // sticky source flags, set wins over clear
    r_next.src_flag = (r_reg.src_flag & ~src_clr) | (src_event & src_ok);
    r_next.irq_stat = (r_reg.irq_stat & ~ev_clr) | ev;

    // pins follow the core only while awake
    if (!asleep(r_next.st)) begin
      r_next.port_out = port_drv;
      r_next.port_oe  = port_drv_oe;
    end

    // read data in the following cycle only
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        OFS_STATUS: begin
          r_next.rdata[POS_PWR_DN] = r_reg.power_down_flag;
          r_next.rdata[POS_TMO]    = r_reg.time_out_flag;
        end
        OFS_OPTION:   r_next.rdata[7:0]       = r_reg.option;
        OFS_CONFIG:   r_next.rdata[7:0]       = r_reg.config_word;
        OFS_SRC_EN:   r_next.rdata[NSRC-1:0]  = r_reg.src_en;
        OFS_SRC_FLAG: r_next.rdata[NSRC-1:0]  = r_reg.src_flag;
        OFS_CTRL:     r_next.rdata[POS_IRQ_EN] = r_reg.global_irq_enable;
        OFS_IRQ_STAT: r_next.rdata[IRQ_W-1:0] = r_reg.irq_stat;
        OFS_IRQ_MASK: r_next.rdata[IRQ_W-1:0] = r_reg.irq_mask;
        OFS_STATE:    r_next.rdata[5:0]       = r_reg.st;
        default:      r_next.rdata            = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      r_reg                   <= '0;
      r_reg.st                <= ST_RUN;
      r_reg.power_down_flag   <= 1'b1;
      r_reg.time_out_flag     <= 1'b1;
      r_reg.option            <= OPTION_RST;
      r_reg.config_word       <= CONFIG_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // oscillator driver off in ST_SLEEP only, back on for the start-up wait
  assign osc_run            = (r_reg.st != ST_SLEEP);
  assign device_reset       = r_reg.dev_rst;
  assign irq                = |(r_reg.irq_stat & r_reg.irq_mask);
  assign bus_rdata          = r_reg.rdata;
  assign port_out           = r_reg.port_out;
  assign port_oe            = r_reg.port_oe;
  assign vector_addr        = IRQ_VECTOR;
  assign core_ack.run       = (r_reg.st == ST_RUN);
  assign core_ack.prefetch  = r_reg.prefetch;
  assign core_ack.exec_next = r_reg.exec_next;
  assign core_ack.vec_req   = r_reg.vec_req;
  assign core_ack.sleep_nop = r_reg.sleep_nop;

endmodule // swc_sleep_ctrl

`default_nettype wire

// ===== swc_pkg.sv
package swc_pkg;

  // timing at the core clock
  localparam int CLK_MHZ        = 40;
  localparam int WDT_PERIOD_US  = 18000;
  localparam int WDT_CYCLES     = WDT_PERIOD_US * CLK_MHZ;
  localparam int OST_CYCLES     = 1024;
  localparam int DUMMY_CYCLES   = 2;
  localparam int OST_W          = 11;
  localparam int WDT_POST_W     = 7;

  // register bus
  localparam int AW = 16;
  localparam int DW = 16;
  localparam logic [AW-1:0] OFS_STATUS   = 16'h0003;
  localparam logic [AW-1:0] OFS_OPTION   = 16'h0081;
  localparam logic [AW-1:0] OFS_CONFIG   = 16'h2007;
  localparam logic [AW-1:0] OFS_SRC_EN   = 16'h0100;
  localparam logic [AW-1:0] OFS_SRC_FLAG = 16'h0101;
  localparam logic [AW-1:0] OFS_CTRL     = 16'h0102;
  localparam logic [AW-1:0] OFS_IRQ_STAT = 16'h0103;
  localparam logic [AW-1:0] OFS_IRQ_MASK = 16'h0104;
  localparam logic [AW-1:0] OFS_STATE    = 16'h0105;

  // field positions
  localparam int POS_PWR_DN    = 3;
  localparam int POS_TMO       = 4;
  localparam int POS_POST_ON   = 3;
  localparam int POS_PS_LO     = 0;
  localparam int PS_W          = 3;
  localparam int POS_WDT_FUSE  = 2;
  localparam int POS_IRQ_EN    = 0;

  // reset values
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [7:0] CONFIG_RST = 8'hFF;

  // wake sources: 0 int pin, 1 port b change, 2 timer one async,
  // 3 serial start/stop, 4 serial slave, 5 capture, 6 parallel slave,
  // 7 a/d on rc clock, 8 usart sync slave, 9 core-clocked peripherals
  localparam int NSRC = 10;
  localparam logic [NSRC-1:0] SRC_CORE_MASK = 10'h200;

  // interrupt status bits
  localparam int IRQ_W        = 4;
  localparam int IRQ_SLEPT    = 0;
  localparam int IRQ_WOKE     = 1;
  localparam int IRQ_WDT_RST  = 2;
  localparam int IRQ_SLP_NOP  = 3;

  localparam logic [12:0] IRQ_VECTOR = 13'h0004;

  typedef enum logic [5:0] {
    ST_RUN   = 6'b00_0001,
    ST_SLEEP = 6'b00_0010,
    ST_OST   = 6'b00_0100,
    ST_EXEC  = 6'b00_1000,
    ST_DUMMY = 6'b01_0000,
    ST_VEC   = 6'b10_0000
  } swc_state_e;

  typedef struct packed {
    logic          wr;
    logic          rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } swc_bus_req_s;

  typedef struct packed {
    logic sleep_instr;
    logic wdt_clear_instr;
  } swc_core_req_s;

  typedef struct packed {
    logic        run;
    logic        prefetch;
    logic        exec_next;
    logic        vec_req;
    logic        sleep_nop;
  } swc_core_ack_s;

  typedef struct packed {
    swc_state_e      st;
    logic            power_down_flag;
    logic            time_out_flag;
    logic [7:0]      option;
    logic [7:0]      config_word;
    logic [NSRC-1:0] src_en;
    logic [NSRC-1:0] src_flag;
    logic            global_irq_enable;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [DW-1:0]   rdata;
    logic [OST_W-1:0] cnt;
    logic            irq_wake;
    logic [7:0]      port_out;
    logic [7:0]      port_oe;
    logic            wdt_clr;
    logic            dev_rst;
    logic            prefetch;
    logic            exec_next;
    logic            vec_req;
    logic            sleep_nop;
  } swc_regs_s;

endpackage

// ===== swc_watchdog.sv
`timescale 1ns/1ps
`default_nettype none

module swc_watchdog
  import swc_pkg::*;
#(
  parameter int TICK_CYCLES = WDT_CYCLES
) (
  // clock and reset
  input  wire logic            clk_sys,
  input  wire logic            nrst,
  // control
  input  wire logic            enable,
  input  wire logic            clear,
  input  wire logic            post_on,
  input  wire logic [PS_W-1:0] post_sel,
  // event
  output logic                 timeout
);

  localparam int BW = $clog2(TICK_CYCLES + 1);
  localparam logic [BW-1:0] BASE_LAST = BW'(TICK_CYCLES - 1);

  typedef struct packed {
    logic [BW-1:0]         base;
    logic [WDT_POST_W-1:0] post;
    logic                  tmo;
  } swc_wdt_s;

  swc_wdt_s r_reg;
  swc_wdt_s r_next;
  logic [WDT_POST_W-1:0] post_last;

  // postscaler ratio 1:2^sel, only when assigned to the watchdog
  assign post_last = post_on ? WDT_POST_W'((8'h01 << post_sel) - 8'h01)
                             : '0;

  always_comb begin
    r_next     = r_reg;
    r_next.tmo = 1'b0;
    if (clear || !enable) begin
      r_next.base = '0;
      r_next.post = '0;
    end else if (r_reg.base == BASE_LAST) begin
      r_next.base = '0;
      if (r_reg.post >= post_last) begin
        r_next.post = '0;
        r_next.tmo  = 1'b1;
      end else begin
        r_next.post = r_reg.post + WDT_POST_W'(1);
      end
    end else begin
      r_next.base = r_reg.base + BW'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign timeout = r_reg.tmo;

endmodule // swc_watchdog

`default_nettype wire

// ===== swc_sleep_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none

module swc_sleep_ctrl_sva
  import swc_pkg::*;
(
  // clock and reset
  input wire logic          clk_sys,
  input wire logic          nrst,
  // core side
  input wire swc_core_req_s core_req,
  input wire swc_core_ack_s core_ack,
  input wire logic [12:0]   vector_addr,
  // pins and system
  input wire logic          master_clear_n,
  input wire logic [7:0]    port_out,
  input wire logic [7:0]    port_oe,
  input wire logic          osc_run,
  input wire logic          device_reset
);
  // restart cycles since the oscillator came back
  logic [11:0] up_reg;
  logic [11:0] up_next;

  always_comb up_next = (osc_run && !core_ack.run) ? up_reg + 12'h001 : '0;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) up_reg <= '0;
    else up_reg <= up_next;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sleep_entry_a: assert property (
    $fell(osc_run) |-> $past(core_req.sleep_instr))
    else $error("oscillator stopped without sleep");
  prefetch_slp_a: assert property (
    core_ack.prefetch |-> !osc_run && $past(core_req.sleep_instr))
    else $error("prefetch outside sleep entry");
  port_hold_a: assert property (
    !osc_run && $past(!osc_run) |-> $stable(port_out) && $stable(port_oe))
    else $error("pins moved while asleep");
  ost_wait_a: assert property (
    core_ack.exec_next |-> up_reg == 12'(OST_CYCLES + 1))
    else $error("start-up delay wrong");
  vec_branch_a: assert property (
    core_ack.exec_next && !core_ack.run |->
      ##3 core_ack.vec_req && vector_addr == 13'h0004)
    else $error("vector branch late or wrong");
  seq_resume_a: assert property (
    core_ack.exec_next && core_ack.run |-> !core_ack.vec_req [*4])
    else $error("branch without global enable");
  slp_no_rst_a: assert property (!osc_run |-> !device_reset)
    else $error("reset while asleep");
  clear_rst_a: assert property (!master_clear_n |=> device_reset)
    else $error("master clear gave no reset");
  nop_runs_a: assert property (
    core_ack.sleep_nop |-> osc_run && $past(core_req.sleep_instr))
    else $error("no-op sleep stopped clock");
endmodule // swc_sleep_ctrl_sva

bind swc_sleep_ctrl swc_sleep_ctrl_sva i_swc_sleep_ctrl_sva (
  .clk_sys, .nrst, .core_req, .core_ack, .vector_addr, .master_clear_n,
  .port_out, .port_oe, .osc_run, .device_reset);

`default_nettype wire

// ===== swc_src_model.sv
`timescale 1ns/1ps
`default_nettype none

module swc_src_model
  import swc_pkg::*;
(
  // clock and reset
  input wire logic             clk_sys,
  input wire logic             nrst,
  // requests
  input wire logic [NSRC-1:0]  ev_req,
  input wire logic             clear_pin_req,
  // to the block
  output logic [NSRC-1:0]      src_event,
  output logic                 master_clear_n
);
  // sources answer one cycle after request, like a synchroniser
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      src_event      <= '0;
      master_clear_n <= 1'b1;
    end else begin
      src_event      <= ev_req;
      master_clear_n <= !clear_pin_req;
    end
  end
endmodule // swc_src_model

`default_nettype wire

// ===== swc_sleep_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none

module swc_sleep_ctrl_tb
  import swc_pkg::*;
;
  logic          clk_sys;
  logic          nrst = 1'b0;
  swc_bus_req_s  bus_req = '0;
  logic [15:0]   bus_rdata;
  swc_core_req_s core_req = '0;
  swc_core_ack_s core_ack;
  logic [12:0]   vector_addr;
  logic [9:0]    src_event;
  logic [9:0]    ev_req = '0;
  logic          clear_pin_req = 1'b0;
  logic          master_clear_n;
  logic [7:0]    port_drv = '0;
  logic [7:0]    port_drv_oe = '0;
  logic [7:0]    port_out;
  logic [7:0]    port_oe;
  logic          osc_run;
  logic          device_reset;
  logic          irq;
  int            n_fail = 0;
  int            checked = 0;
  int            cyc = 0;

  swc_sleep_ctrl #(.WDT_TICK_CYCLES(64)) i_swc_sleep_ctrl (
    .clk_sys, .nrst, .bus_req, .bus_rdata, .core_req, .core_ack,
    .vector_addr, .src_event, .master_clear_n, .port_drv, .port_drv_oe,
    .port_out, .port_oe, .osc_run, .device_reset, .irq);
  swc_src_model i_swc_src_model (
    .clk_sys, .nrst, .ev_req, .clear_pin_req, .src_event, .master_clear_n);

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // three wakes of about 1100 cycles each, ample margin
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    bus_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    bus_req <= '0;
  endtask

  task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    bus_req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk_sys);
    bus_req <= '0;
    #1 chk(bus_rdata, exp);
  endtask

  task automatic pulse(input logic [9:0] v);
    @(posedge clk_sys);
    ev_req <= v;
    @(posedge clk_sys);
    ev_req <= '0;
  endtask

  task automatic op(input logic slp, input logic clr);
    @(posedge clk_sys);
    core_req <= '{slp, clr};
    @(posedge clk_sys);
    core_req <= '0;
    #1;
  endtask

  // 0 exec_next, 1 vec_req, 2 osc_run, 3 device_reset
  task automatic wait_sig(input int k);
    logic s;
    for (int n = 0; n < 3000; n++) begin
      @(posedge clk_sys);
      #1 s = k == 0 ? core_ack.exec_next : k == 1 ? core_ack.vec_req
           : k == 2 ? osc_run : device_reset;
      if (s === 1'b1) break;
    end
  endtask

  task automatic t_reset;
    rdc(OFS_STATUS, 16'h0018);
    rdc(OFS_OPTION, 16'h00FF);
    rdc(OFS_CONFIG, 16'h00FF);
    rdc(16'h0200, 16'h0000);
    rdc(OFS_STATE, 16'h0001);
    chk(irq, 1'b0);
    // watchdog off so the awake tests cannot be reset under us
    wr(OFS_CONFIG, 16'h00FB);
    $display("test reset done");
  endtask

  task automatic t_nop;
    wr(OFS_SRC_EN, 16'h0001);
    pulse(10'h001);
    op(1'b1, 1'b0);
    chk(core_ack.sleep_nop, 1'b1);
    chk(osc_run, 1'b1);
    rdc(OFS_STATUS, 16'h0018);
    wr(OFS_SRC_FLAG, 16'h0001);
    rdc(OFS_SRC_FLAG, 16'h0000);
    $display("test nop done");
  endtask

  task automatic t_irq_wake;
    wr(OFS_SRC_EN, 16'h0202);
    @(posedge clk_sys);
    port_drv <= 8'hA5;
    port_drv_oe <= 8'h3C;
    op(1'b0, 1'b1);
    op(1'b1, 1'b0);
    chk(osc_run, 1'b0);
    chk(core_ack.prefetch, 1'b1);
    @(posedge clk_sys);
    port_drv <= 8'h5A;
    port_drv_oe <= 8'hC3;
    rdc(OFS_STATUS, 16'h0010);
    pulse(10'h200);
    repeat (4) @(posedge clk_sys);
    #1 chk(osc_run, 1'b0);
    chk(port_out, 8'hA5);
    chk(port_oe, 8'h3C);
    rdc(OFS_STATE, 16'h0002);
    pulse(10'h002);
    wait_sig(0);
    chk(core_ack.exec_next, 1'b1);
    chk(core_ack.run, 1'b1);
    wr(OFS_SRC_FLAG, 16'h03FF);
    $display("test irq wake done");
  endtask

  task automatic t_vec;
    wr(OFS_SRC_EN, 16'h0004);
    wr(OFS_CTRL, 16'h0001);
    @(posedge clk_sys);
    ev_req <= 10'h004;
    @(posedge clk_sys);
    ev_req <= '0;
    core_req <= '{1'b1, 1'b0};
    @(posedge clk_sys);
    core_req <= '0;
    #1 chk(core_ack.prefetch, 1'b1);
    wait_sig(0);
    chk(core_ack.run, 1'b0);
    wait_sig(1);
    chk(core_ack.vec_req, 1'b1);
    chk(vector_addr, 16'h0004);
    rdc(OFS_STATUS, 16'h0010);
    wr(OFS_SRC_FLAG, 16'h03FF);
    wr(OFS_CTRL, 16'h0000);
    $display("test vector done");
  endtask

  task automatic t_wdt;
    wr(OFS_SRC_EN, 16'h0000);
    wr(OFS_OPTION, 16'h00F7);
    wr(OFS_CONFIG, 16'h00FF);
    op(1'b0, 1'b1);
    op(1'b1, 1'b0);
    chk(osc_run, 1'b0);
    wait_sig(2);
    chk(osc_run, 1'b1);
    rdc(OFS_STATUS, 16'h0000);
    wait_sig(3);
    chk(device_reset, 1'b1);
    wr(OFS_CONFIG, 16'h00FB);
    $display("test watchdog done");
  endtask

  task automatic t_clear_pin;
    op(1'b1, 1'b0);
    @(posedge clk_sys);
    clear_pin_req <= 1'b1;
    @(posedge clk_sys);
    clear_pin_req <= 1'b0;
    wait_sig(3);
    chk(device_reset, 1'b1);
    chk(core_ack.run, 1'b1);
    chk(osc_run, 1'b1);
    $display("test master clear done");
  endtask

  task automatic t_irq;
    chk(irq, 1'b0);
    wr(OFS_IRQ_MASK, 16'h000F);
    #1 chk(irq, 1'b1);
    rdc(OFS_IRQ_STAT, 16'h000F);
    wr(OFS_IRQ_STAT, 16'h000F);
    #1 chk(irq, 1'b0);
    rdc(OFS_IRQ_STAT, 16'h0000);
    $display("test interrupt done");
  endtask

  // power-up state must come back after sleeps cleared power-down
  task automatic t_mid_reset;
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    $display("test mid reset done");
  endtask

  initial begin
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    t_nop();
    t_irq_wake();
    t_vec();
    t_wdt();
    t_clear_pin();
    t_irq();
    t_mid_reset();
    tally_and_finish();
  end
endmodule // swc_sleep_ctrl_tb

`default_nettype wire
